/* File: rtl/dadc_consts.vh */
// Purpose: shared constants of the dual converter output control
// Assumes: 50 MHz system clock, 10-bit conversion words
// Notes: definitions only
`ifndef DADC_CONSTS_VH
`define DADC_CONSTS_VH
`define DADC_W 10
`define DADC_TRIM_CYCLES 6'h22
`define DADC_TRIM_SAMPLES 6'h20
`define DADC_AVG_SHIFT 5
`define DADC_CODE_MAX 10'h3ff
`define DADC_CODE_MIN 10'h000
`define DADC_MIDSCALE 10'h200
`endif

/* File: rtl/dadc_sampler.v */
// Purpose: falling-edge sampler for one channel
// Assumes: sample strobe is the falling clock edge of the conversion clock
// Notes: holds the last sample while not enabled
`timescale 1ns/1ps
`default_nettype none
`include "dadc_consts.vh"
module dadc_sampler (
	input wire clock_i,
	input wire sys_rst_i,
	input wire run_i,
	input wire [`DADC_W-1:0] analog_code_i,
	output reg [`DADC_W-1:0] sample_o
);
	// capture on the falling edge, shared by both channels
	always @(negedge clock_i)
	begin
		if (sys_rst_i)
			sample_o <= `DADC_MIDSCALE;
		else if (run_i)
			sample_o <= analog_code_i;
	end
endmodule
`default_nettype wire

/* File: rtl/dadc_trim.v */
// Purpose: offset trim and correction for one channel
// Assumes: raw codes arrive as offset binary, one per clock
// Notes: coefficient is signed, offset from midscale
`timescale 1ns/1ps
`default_nettype none
`include "dadc_consts.vh"
module dadc_trim (
	input wire clock_i,
	input wire sys_rst_i,
	input wire start_i,
	input wire run_i,
	input wire [`DADC_W-1:0] raw_i,
	output reg [`DADC_W-1:0] corr_o,
	output reg busy_o
);
	reg [5:0] count; // cycles into the sequence
	reg [15:0] acc; // sum of the samples taken
	reg signed [10:0] coef; // offset from midscale
	wire signed [11:0] diff;
	wire signed [11:0] sum_off;
	reg [`DADC_W-1:0] next_corr;
	assign diff = $signed({2'b00, raw_i}) - $signed(12'sh200) - coef;
	assign sum_off = $signed({1'b0, acc[15:5]}) - $signed(12'sh200);
	// clamp the corrected code into range
	always @*
	begin
		if (diff < -12'sh200)
			next_corr = `DADC_CODE_MIN;
		else if (diff > 12'sh1ff)
			next_corr = `DADC_CODE_MAX;
		else
			next_corr = diff[9:0] ^ 10'h200;
	end
	// sequence: one settle cycle, 32 samples, one finish cycle
	always @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			count <= 6'h00;
			acc <= 16'h0000;
			coef <= 11'sh000;
			busy_o <= 1'b0;
			corr_o <= `DADC_MIDSCALE;
		end
		else
		begin
			if (run_i)
				corr_o <= next_corr;
			if (!busy_o)
			begin
				if (start_i)
				begin
					busy_o <= 1'b1;
					count <= 6'h00;
					acc <= 16'h0000;
				end
			end
			else
			begin
				count <= count + 6'h01;
				if (count >= 6'h01 && count <= `DADC_TRIM_SAMPLES)
					acc <= acc + {6'h00, raw_i};
				if (count == `DADC_TRIM_CYCLES - 6'h01)
				begin
					busy_o <= 1'b0;
					coef <= sum_off[10:0];
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: rtl/dadc_top.v */
// Purpose: control and output logic of a dual 10-bit sampling converter
// Assumes: analog front end delivers offset-binary codes per channel
// Notes: static select pins; data and phase outputs hold during sleep modes
`timescale 1ns/1ps
`default_nettype none
`include "dadc_consts.vh"
// What this block does
// - sample both channels on falling edge
// - select high gives parallel buses
// - select low interleaves on I bus
// - trigger rise starts per-channel trim
// - trim lasts 34 cycles, 32 samples
// - subtract averaged offset from later codes
// - output range shrinks by the offset
// - coefficients start at zero
// - format select picks binary or complement
// - full-scale and zero codes as tabled
// - convert only when both sleeps low
// - quick sleep holds last result
// - deep sleep holds last result
// - deep sleep wins over quick sleep
// - parallel latency 2.5 cycles
// - muxed I 2.5, Q 3.5 cycles
module dadc_top (
	input wire clock_i,
	input wire sys_rst_i,
	input wire [9:0] analog_i_i,
	input wire [9:0] analog_q_i,
	input wire bus_layout_select_i,
	input wire offset_trim_trigger_i,
	input wire code_format_select_i,
	input wire quick_sleep_i,
	input wire deep_sleep_i,
	output reg [9:0] data_i_o,
	output reg [9:0] data_q_o,
	output reg q_phase_o,
	output reg trim_busy_o,
	output reg power_down_o
);
	wire run; // converter active
	wire [9:0] samp_i;
	wire [9:0] samp_q;
	wire [9:0] corr_i;
	wire [9:0] corr_q;
	wire busy_i;
	wire busy_q;
	reg trig_d; // previous trigger level
	reg phase; // muxed-mode half select
	reg [9:0] hold_q; // q word kept for the muxed slot
	reg [9:0] stage_i; // extra stage so words leave 2.5 cycles after sampling
	reg [9:0] stage_q; // same stage for the q channel
	reg [9:0] next_i;
	reg [9:0] next_q;
	wire start;
	assign run = ~quick_sleep_i & ~deep_sleep_i;
	assign start = offset_trim_trigger_i & ~trig_d;
	dadc_sampler u_samp_i (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.run_i(run),
		.analog_code_i(analog_i_i),
		.sample_o(samp_i)
	);
	dadc_sampler u_samp_q (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.run_i(run),
		.analog_code_i(analog_q_i),
		.sample_o(samp_q)
	);
	dadc_trim u_trim_i (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.start_i(start),
		.run_i(run),
		.raw_i(samp_i),
		.corr_o(corr_i),
		.busy_o(busy_i)
	);
	dadc_trim u_trim_q (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.start_i(start),
		.run_i(run),
		.raw_i(samp_q),
		.corr_o(corr_q),
		.busy_o(busy_q)
	);
	// format and route the corrected words
	always @*
	begin
		if (bus_layout_select_i)
		begin
			next_i = stage_i;
			next_q = stage_q;
		end
		else
		begin
			next_i = phase ? hold_q : stage_i;
			next_q = 10'h000;
		end
		if (code_format_select_i)
		begin
			next_i = next_i ^ 10'h200;
			if (bus_layout_select_i)
				next_q = next_q ^ 10'h200;
		end
	end
	// data and phase output registers hold while sleeping; trim busy and power down still follow
	always @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			trig_d <= 1'b0;
			phase <= 1'b0;
			hold_q <= `DADC_MIDSCALE;
			stage_i <= `DADC_MIDSCALE;
			stage_q <= `DADC_MIDSCALE;
			data_i_o <= `DADC_MIDSCALE;
			data_q_o <= 10'h000;
			q_phase_o <= 1'b0;
			trim_busy_o <= 1'b0;
			power_down_o <= 1'b0;
		end
		else
		begin
			trig_d <= offset_trim_trigger_i;
			trim_busy_o <= busy_i | busy_q;
			power_down_o <= deep_sleep_i;
			if (run)
			begin
				phase <= ~phase;
				// latency stage, frozen with the rest while asleep
				stage_i <= corr_i;
				stage_q <= corr_q;
				if (!phase)
					hold_q <= stage_q;
				data_i_o <= next_i;
				data_q_o <= next_q;
				q_phase_o <= phase & ~bus_layout_select_i;
			end
		end
	end
endmodule
`default_nettype wire

/* File: verif/dadc_top_sva.sv */
// Purpose: port assertions for the dual converter output control
// Assumes: one clock, synchronous reset active high
// Notes: bound onto every dadc_top
`timescale 1ns/1ps
`default_nettype none
module dadc_top_sva (
	input wire logic clock_i, sys_rst_i, bus_layout_select_i,
	input wire logic offset_trim_trigger_i, quick_sleep_i, deep_sleep_i,
	input wire logic [9:0] data_i_o, data_q_o,
	input wire logic q_phase_o, trim_busy_o, power_down_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	a_reset_words: assert property (
		$fell(sys_rst_i) |-> data_i_o == 10'h200 && data_q_o == 10'h000)
		else $error("reset words wrong");
	a_q_bus_low: assert property (
		!bus_layout_select_i && !$past(bus_layout_select_i, 3)
		|-> data_q_o == 10'h000) else $error("q bus not low");
	a_pd_enter: assert property (
		deep_sleep_i |-> ##[1:2] power_down_o) else $error("no power down");
	a_pd_leave: assert property (
		!deep_sleep_i |-> ##[1:2] !power_down_o) else $error("stuck down");
	a_trim_start: assert property (
		$rose(offset_trim_trigger_i) && !trim_busy_o |-> ##[1:2] trim_busy_o)
		else $error("trim not started");
	a_trim_length: assert property (
		$rose(trim_busy_o) |-> ##33 trim_busy_o ##1 !trim_busy_o)
		else $error("trim length wrong");
	a_deep_hold: assert property (
		deep_sleep_i && $past(deep_sleep_i, 3)
		|-> $stable(data_i_o) && $stable(data_q_o)) else $error("pd moved");
	a_quick_hold: assert property (
		quick_sleep_i && $past(quick_sleep_i, 3) |-> $stable(data_i_o))
		else $error("sleep moved");
	cover property ($fell(trim_busy_o));
	cover property (power_down_o && quick_sleep_i);
	cover property (!bus_layout_select_i && q_phase_o);
endmodule
bind dadc_top dadc_top_sva dadc_top_sva_i (.*);
`default_nettype wire

/* File: verif/dadc_capture.sv */
// Purpose: capture model latching converter output words
// Assumes: words settle before the rising edge
// Notes: muxed words sorted by the q phase flag
`timescale 1ns/1ps
`default_nettype none
module dadc_capture (
	input wire logic clock_i, layout_i, q_phase_i,
	input wire logic [9:0] data_i_i, data_q_i,
	output logic [9:0] word_i_o, word_q_o
);
	// parallel takes both buses, muxed sorts by phase
	always @(posedge clock_i)
		if (layout_i)
		begin
			word_i_o <= data_i_i;
			word_q_o <= data_q_i;
		end
		else if (q_phase_i)
			word_q_o <= data_i_i;
		else
			word_i_o <= data_i_i;
endmodule
`default_nettype wire

/* File: verif/dadc_top_tb.sv */
// Purpose: self-checking bench for dadc_top
// Assumes: inputs move 1 ns after the rising edge
// Notes: expectations from the coding and trim behaviour
`timescale 1ns/1ps
`default_nettype none
module dadc_top_tb;
	logic clock_i = 1'b0, sys_rst_i = 1'b1, sel = 1'b1, trig = 1'b0;
	logic fmt = 1'b0, qs = 1'b0, ds = 1'b0;
	logic [9:0] ai = 10'h200, aq = 10'h200;
	wire logic [9:0] di, dq, ci, cq;
	wire logic ph, busy, pd;
	int miscompares = 0, total_checks = 0, cycles = 0, n;
	always #10 clock_i = ~clock_i; // bench clock, logic is rate free
	dadc_top dadc_top_i (.clock_i, .sys_rst_i, .analog_i_i(ai),
		.analog_q_i(aq), .bus_layout_select_i(sel),
		.offset_trim_trigger_i(trig), .code_format_select_i(fmt),
		.quick_sleep_i(qs), .deep_sleep_i(ds), .data_i_o(di),
		.data_q_o(dq), .q_phase_o(ph), .trim_busy_o(busy),
		.power_down_o(pd));
	dadc_capture dadc_capture_i (.clock_i, .layout_i(sel),
		.q_phase_i(ph), .data_i_i(di), .data_q_i(dq),
		.word_i_o(ci), .word_q_o(cq));
	task automatic check(input logic [9:0] seen, exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clock_i);
		#1;
	endtask
	// hold raw codes steady, then judge the captured words
	task automatic conv(input logic [9:0] i, q, ei, eq);
		ai = i;
		aq = q;
		cyc(8);
		check(ci, ei);
		check(cq, eq);
	endtask
	task automatic results;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		cyc(2);
		sys_rst_i = 1'b0;
		conv(10'h3ff, 10'h000, 10'h3ff, 10'h000);
		fmt = 1'b1;
		conv(10'h3ff, 10'h000, 10'h1ff, 10'h200);
		conv(10'h200, 10'h200, 10'h000, 10'h000);
		fmt = 1'b0;
		conv(10'h205, 10'h1fc, 10'h205, 10'h1fc);
		trig = 1'b1; // one trim after power-up
		// edge that takes the rise; busy shows one edge later
		cyc(1);
		// second rise at cycle 13 lands mid-trim
		for (n = 1; n < 60; n++)
		begin
			cyc(1);
			trig = (n < 10 || n > 12);
			if (busy !== 1'b1)
				break;
		end
		check(10'(n), 10'h023);
		trig = 1'b0;
		cyc(3); // 3 more periods before using results
		check({9'h000, busy}, 10'h000);
		conv(10'h3ff, 10'h000, 10'h3fa, 10'h004);
		conv(10'h002, 10'h3ff, 10'h000, 10'h3ff);
		qs = 1'b1;
		cyc(2);
		ai = 10'h3ff;
		cyc(6);
		check(di, 10'h000);
		ds = 1'b1;
		cyc(4);
		check({9'h000, pd}, 10'h001);
		qs = 1'b0;
		cyc(4);
		check(dq, 10'h3ff);
		ds = 1'b0;
		cyc(8);
		check(di, 10'h3fa);
		sel = 1'b0;
		conv(10'h2ff, 10'h0f0, 10'h2fa, 10'h0f4);
		check(dq, 10'h000);
		results;
	end
	// cut a hang short
	always @(posedge clock_i)
		if (++cycles == 1000)
		begin
			miscompares++;
			results;
		end
endmodule
`default_nettype wire
